// *** shared/umrc_pkg.sv ***
// Package for the UART multiprocessor receive control block.
// Assumes a single 125 MHz system clock; SFR bus is byte wide.
package umrc_pkg;

  localparam logic [7:0] CTRL_ADDR     = 8'h98;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam int         BIT_MODE0_ERR = 7;
  localparam int         BIT_MODE1     = 6;
  localparam int         BIT_FILTER    = 5;
  localparam int         BIT_REN       = 4;
  localparam int         BIT_TX_NINTH  = 3;
  localparam int         BIT_RX_NINTH  = 2;
  localparam int         BIT_TX_DONE   = 1;
  localparam int         BIT_RX_DONE   = 0;
  localparam int         FIFO_DEPTH   = 16;

  typedef enum logic [1:0]
  {
    MODE_SHIFT = 2'h0,
    MODE_UART8 = 2'h1,
    MODE_UART9F = 2'h2,
    MODE_UART9V = 2'h3
  } umrc_mode_type;

  // One frame as handed over by the bit-level receiver.
  typedef struct packed
  {
    logic [7:0] data;
    logic       ninth;
    logic       stop;
  } umrc_frame_type;

endpackage : umrc_pkg

// *** verilog/umrc_top.sv ***
// Serial port control register and receive-side frame acceptance.
// Assumes the bit-level receiver delivers frames on the same clock and that
// the SFR bus writes and reads within one cycle.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////

module umrc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_depth_check
    $error("umrc_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_reg != rd_reg;
  assign out_data_o  = mem_reg[rd_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // Storage needs no reset; the pointers guard it.
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem_reg[wr_reg[AW-1:0]] <= in_data_i;
  end
endmodule : umrc_fifo

////////////////////////////////////////////////////////////////////////////////

module umrc_top #(
  parameter int DEPTH = umrc_pkg::FIFO_DEPTH
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic [7:0]               sfr_addr_i,
  input  wire logic                     sfr_wr_i,
  input  wire logic                     sfr_rd_i,
  input  wire logic [7:0]               sfr_wdata_i,
  output logic      [7:0]               sfr_rdata_o,
  input  wire logic                     sfr_bit_wr_i,
  input  wire logic [2:0]               sfr_bit_sel_i,
  input  wire logic                     sfr_bit_val_i,
  input  wire logic                     framing_error_access_select_i,
  input  wire logic                     frame_valid_i,
  output logic                          frame_ready_o,
  input  wire umrc_pkg::umrc_frame_type frame_i,
  input  wire logic                     tx_done_set_i,
  output logic                          rx_data_valid_o,
  input  wire logic                     rx_data_ready_i,
  output logic      [7:0]               rx_data_o,
  output umrc_pkg::umrc_mode_type       mode_o,
  output logic                          receive_enable_o,
  output logic                          transmit_ninth_bit_o,
  output logic                          serial_irq_o
);
  // Control register bits.
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic       ferr_reg;
  logic       ferr_next;
  logic       sel_hit;
  logic [7:0] wr_mask;
  logic [7:0] wr_val;
  umrc_pkg::umrc_mode_type mode;

  // Frame path through the FIFO.
  umrc_pkg::umrc_frame_type fifo_frame;
  logic       fifo_valid;
  logic       fifo_pop;
  logic       accept;
  logic       stop_bad;
  logic       take_frame;
  logic       nine_bit_mode;
  logic       filter_on;
  logic       ferr_clear;
  logic       out_valid_reg;
  logic       out_valid_next;
  logic [7:0] out_data_reg;
  logic [7:0] out_data_next;

  // A smaller store could not hold a frame while the next one arrives.
  if (DEPTH < 2)
  begin : g_depth_check
    $error("umrc_top: DEPTH must be at least 2");
  end

  umrc_fifo #(
    .WIDTH ($bits(umrc_pkg::umrc_frame_type)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (frame_valid_i && ctrl_reg[umrc_pkg::BIT_REN]),
    .in_ready_o  (frame_ready_o),
    .in_data_i   (frame_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_frame)
  );

  //////////////////////////////////////////////////////////////////////////////

  assign mode = umrc_pkg::umrc_mode_type'({ctrl_reg[umrc_pkg::BIT_MODE0_ERR],
                                          ctrl_reg[umrc_pkg::BIT_MODE1]});
  assign sel_hit = sfr_addr_i == umrc_pkg::CTRL_ADDR;
  assign nine_bit_mode = (mode == umrc_pkg::MODE_UART9F) ||
                         (mode == umrc_pkg::MODE_UART9V);
  assign filter_on = ctrl_reg[umrc_pkg::BIT_FILTER];
  // Stall frame handling while the holding register is unread.
  assign fifo_pop = fifo_valid && !(out_valid_reg && !rx_data_ready_i);
  // Shift-register mode has no stop bit, so it never flags framing.
  assign stop_bad = (mode != umrc_pkg::MODE_SHIFT) && !fifo_frame.stop;
  assign take_frame = fifo_pop && accept;
  // A software zero only reaches the flag while bit 7 is mapped onto it.
  assign ferr_clear = framing_error_access_select_i &&
                      wr_mask[umrc_pkg::BIT_MODE0_ERR] &&
                      !wr_val[umrc_pkg::BIT_MODE0_ERR];

  always_comb
  begin
    case (mode)
      umrc_pkg::MODE_SHIFT:
        accept = 1'b1;
      umrc_pkg::MODE_UART8:
        accept = !filter_on || fifo_frame.stop;
      umrc_pkg::MODE_UART9F,
      umrc_pkg::MODE_UART9V:
        accept = !filter_on || fifo_frame.ninth;
      default:
        accept = 1'b0;
    endcase
  end

  always_comb
  begin
    wr_mask = 8'h00;
    wr_val  = sfr_wdata_i;
    if (sel_hit && sfr_wr_i)
      wr_mask = 8'hFF;
    else if (sel_hit && sfr_bit_wr_i)
    begin
      wr_mask = 8'h01 << sfr_bit_sel_i;
      wr_val  = {8{sfr_bit_val_i}};
    end
  end

  // Hardware sets are applied last, so they win over a software clear that
  // lands in the same cycle; no event is lost that way.
  always_comb
  begin
    ctrl_next = (ctrl_reg & ~wr_mask) | (wr_val & wr_mask);
    if (framing_error_access_select_i)
      ctrl_next[umrc_pkg::BIT_MODE0_ERR] =
        ctrl_reg[umrc_pkg::BIT_MODE0_ERR];
    if (tx_done_set_i)
      ctrl_next[umrc_pkg::BIT_TX_DONE] = 1'b1;
    if (take_frame)
    begin
      ctrl_next[umrc_pkg::BIT_RX_DONE] = 1'b1;
      if (nine_bit_mode)
        ctrl_next[umrc_pkg::BIT_RX_NINTH] = fifo_frame.ninth;
      else if (mode == umrc_pkg::MODE_UART8 && !filter_on)
        ctrl_next[umrc_pkg::BIT_RX_NINTH] = fifo_frame.stop;
    end
  end

  // The flag lives apart from the register because bit 7 also holds a mode
  // bit; it is set in every framed mode, whatever the select says.
  always_comb
  begin
    ferr_next = ferr_reg;
    if (ferr_clear)
      ferr_next = 1'b0;
    if (fifo_pop && stop_bad)
      ferr_next = 1'b1;
  end

  // No byte is lost: a full holding register stalls the FIFO instead.
  always_comb
  begin
    out_valid_next = out_valid_reg && !rx_data_ready_i;
    out_data_next  = out_data_reg;
    if (take_frame)
    begin
      out_valid_next = 1'b1;
      out_data_next  = fifo_frame.data;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_reg <= umrc_pkg::CTRL_RESET;
    else
      ctrl_reg <= ctrl_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ferr_reg <= 1'b0;
    else
      ferr_reg <= ferr_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= 8'h00;
    end
    else
    begin
      out_valid_reg <= out_valid_next;
      out_data_reg  <= out_data_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    sfr_rdata_o = 8'h00;
    if (sel_hit && sfr_rd_i)
    begin
      sfr_rdata_o = ctrl_reg;
      if (framing_error_access_select_i)
        sfr_rdata_o[umrc_pkg::BIT_MODE0_ERR] = ferr_reg;
    end
  end

  assign rx_data_valid_o      = out_valid_reg;
  assign rx_data_o            = out_data_reg;
  assign mode_o               = mode;
  assign receive_enable_o     = ctrl_reg[umrc_pkg::BIT_REN];
  assign transmit_ninth_bit_o = ctrl_reg[umrc_pkg::BIT_TX_NINTH];
  assign serial_irq_o         = ctrl_reg[umrc_pkg::BIT_RX_DONE] ||
                                ctrl_reg[umrc_pkg::BIT_TX_DONE];

endmodule : umrc_top

// *** dv/umrc_chk.sv ***
// Checker for the control register and receive flags of umrc_top.
// Assumes it is bound to umrc_top and sees only its ports.
`timescale 1ns/1ns
module umrc_chk (
  input wire logic                    clk_sys_i,
  input wire logic                    rst_i,
  input wire logic [7:0]              sfr_addr_i,
  input wire logic                    sfr_wr_i,
  input wire logic                    sfr_rd_i,
  input wire logic                    sfr_bit_wr_i,
  input wire logic [7:0]              sfr_wdata_i,
  input wire logic [7:0]              sfr_rdata_o,
  input wire logic                    framing_error_access_select_i,
  input wire logic                    tx_done_set_i,
  input wire logic                    rx_data_valid_o,
  input wire logic                    rx_data_ready_i,
  input wire logic [7:0]              rx_data_o,
  input wire umrc_pkg::umrc_mode_type mode_o,
  input wire logic                    receive_enable_o,
  input wire logic                    transmit_ninth_bit_o,
  input wire logic                    serial_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic wr98;
  assign wr98 = sfr_wr_i && sfr_addr_i == 8'h98;
  mode_set_a: assert property (wr98 && !framing_error_access_select_i
    |=> mode_o == $past(sfr_wdata_i[7:6])) else $error("Mode bits wrong.");
  ren_set_a: assert property (wr98
    |=> receive_enable_o == $past(sfr_wdata_i[4])) else $error("Bad enable.");
  tx_ninth_set_a: assert property (wr98
    |=> transmit_ninth_bit_o == $past(sfr_wdata_i[3]))
    else $error("Bad transmit ninth bit.");
  ti_set_a: assert property (tx_done_set_i |=> serial_irq_o)
    else $error("Transmit flag not set.");
  rd_idle_a: assert property (!sfr_rd_i |-> sfr_rdata_o == 8'h00)
    else $error("Read data not zero.");
  irq_hold_a: assert property (serial_irq_o && !sfr_wr_i && !sfr_bit_wr_i
    |=> serial_irq_o) else $error("Flag cleared by hardware.");
  rx_stand_a: assert property (rx_data_valid_o && !rx_data_ready_i
    |=> rx_data_valid_o && $stable(rx_data_o)) else $error("Data dropped.");
  bit7_view_a: assert property (sfr_rd_i && sfr_addr_i == 8'h98
    && !framing_error_access_select_i |-> sfr_rdata_o[7:6] == mode_o)
    else $error("Bit 7 view wrong.");
endmodule : umrc_chk

// *** dv/umrc_peer.sv ***
// Far-side frame source feeding the receive path.
// Assumes the caller holds the clock; frames go out one at a time.
`timescale 1ns/1ns
module umrc_peer (
  input  wire logic               clk_sys_i,
  input  wire logic               frame_ready_o,
  output logic                    frame_valid_i,
  output umrc_pkg::umrc_frame_type frame_i
);
  initial
  begin
    frame_valid_i = 1'b0;
    frame_i = '0;
  end
  // Released lines show the inverse so stale data is never mistaken for new.
  task automatic send(input logic [7:0] d, input logic n, input logic s);
    int w;
    @(negedge clk_sys_i);
    frame_valid_i = 1'b1;
    frame_i = {d, n, s};
    w = 0;
    while (frame_ready_o !== 1'b1 && w < 50)
    begin
      @(negedge clk_sys_i);
      w++;
    end
    @(negedge clk_sys_i);
    frame_valid_i = 1'b0;
    frame_i = ~frame_i;
  endtask : send
endmodule : umrc_peer

// *** dv/umrc_tb.sv ***
// Register-level test of umrc_top with a frame source on the far side.
// Assumes the control register answers reads in the same cycle.
`timescale 1ns/1ns
module testbench;
  logic       clk_sys_i, rst_i, sfr_wr_i, sfr_rd_i, sfr_bit_wr_i;
  logic       sfr_bit_val_i, framing_error_access_select_i, tx_done_set_i;
  logic       frame_valid_i, frame_ready_o, rx_data_valid_o, rx_data_ready_i;
  logic       receive_enable_o, transmit_ninth_bit_o, serial_irq_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rx_data_o;
  logic [2:0] sfr_bit_sel_i;
  umrc_pkg::umrc_frame_type frame_i;
  umrc_pkg::umrc_mode_type  mode_o;
  int         err_total, samples_checked, n, k;
  umrc_top  i_dut (.*);
  umrc_peer i_peer (.*);
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    #1 chk(sfr_rdata_o, exp);
  endtask : rd
  task automatic wr(input logic [7:0] d);
    @(negedge clk_sys_i);
    {sfr_rd_i, sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {1'b0, 8'h98, d, 1'b1};
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
  endtask : wr
  task automatic frm(input logic [7:0] d, input logic n9, input logic s);
    i_peer.send(d, n9, s);
    repeat (2) @(negedge clk_sys_i);
  endtask : frm
  task automatic pop();
    rx_data_ready_i = 1'b1;
    @(negedge clk_sys_i);
    rx_data_ready_i = 1'b0;
  endtask : pop
  task automatic print_verdict();
    $display("Mismatches %0d of %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    #200000 err_total++;
    print_verdict();
  end
  initial
  begin
    {clk_sys_i, sfr_addr_i, sfr_wr_i, sfr_rd_i, sfr_wdata_i} = '0;
    {sfr_bit_wr_i, sfr_bit_sel_i, sfr_bit_val_i, tx_done_set_i} = '0;
    {framing_error_access_select_i, rx_data_ready_i} = '0;
    rst_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rd(8'h98, 8'h00);
    wr(8'hF0); rd(8'h98, 8'hF0);
    frm(8'h3C, 1'b0, 1'b1); rd(8'h98, 8'hF0);
    frm(8'hA5, 1'b1, 1'b1); rd(8'h98, 8'hF5);
    chk(rx_data_o, 8'hA5);
    pop();
    wr(8'h70); frm(8'h11, 1'b0, 1'b0); rd(8'h98, 8'h70);
    framing_error_access_select_i = 1'b1;
    rd(8'h98, 8'hF0);
    wr(8'hD0); frm(8'h22, 1'b0, 1'b1); rd(8'h98, 8'hD5);
    framing_error_access_select_i = 1'b0;
    rd(8'h98, 8'h55);
    pop();
    framing_error_access_select_i = 1'b1;
    wr(8'h50); rd(8'h98, 8'h50);
    framing_error_access_select_i = 1'b0;
    wr(8'h40); frm(8'h33, 1'b1, 1'b1); rd(8'h98, 8'h40);
    chk(rx_data_valid_o, 8'h00);
    @(negedge clk_sys_i) tx_done_set_i = 1'b1;
    @(negedge clk_sys_i) tx_done_set_i = 1'b0;
    rd(8'h98, 8'h42);
    {sfr_bit_sel_i, sfr_bit_val_i, sfr_bit_wr_i} = {3'h1, 1'b0, 1'b1};
    @(negedge clk_sys_i) sfr_bit_wr_i = 1'b0;
    rd(8'h98, 8'h40);
    rd(8'h99, 8'h00);
    wr(8'h14); frm(8'h44, 1'b0, 1'b0); rd(8'h98, 8'h15);
    chk(rx_data_o, 8'h44);
    pop();
    wr(8'h50);
    n = 0;
    while (frame_ready_o === 1'b1 && n < 40)
    begin
      i_peer.send(8'(n), 1'b0, 1'b1);
      n++;
    end
    chk(8'(frame_ready_o), 8'h00);
    chk(8'(n >= 16), 8'h01);
    k = 0;
    repeat (80)
    begin
      if (rx_data_valid_o === 1'b1)
      begin
        chk(rx_data_o, 8'(k));
        k++;
      end
      rx_data_ready_i = 1'b1;
      @(negedge clk_sys_i);
    end
    chk(8'(k), 8'(n));
    print_verdict();
  end
endmodule : testbench
bind umrc_top umrc_chk i_chk (.*);
